// file: hdl/ufb_pkg.sv
package ufb_pkg;
   // Divider prescales
   localparam int LOW_PRESCALE = 64;
   localparam int HIGH_PRESCALE = 16;
   localparam int DIV_W = 8;
   localparam int OS_W = 6;
   // Frame format reset values
   localparam logic FMT_WORD9_RST = 1'h0;
   localparam logic FMT_PARITY_RST = 1'h0;
   localparam logic FMT_STOP2_RST = 1'h0;
   // Word widths
   localparam int WORD8 = 8;
   localparam int WORD9 = 9;
   localparam int DATA_W = 9;
   // Receive samples per bit in prescale units
   localparam int RX_OS = 16;
   typedef enum logic [2:0] {UFB_IDLE, UFB_START, UFB_DATA, UFB_STOP1, UFB_STOP2} ufb_phase_t;
endpackage

// file: hdl/ufb_link_if.sv
`timescale 1ns/100ps
`default_nettype none
interface ufb_link_if;
   logic dev_tx;
   logic dev_tx_oe;
   logic peer_tx;
   // Device to peer line; released line floats high
   logic line_d2p;
   assign line_d2p = dev_tx_oe ? dev_tx : 1'h1;
   modport device (output dev_tx, output dev_tx_oe, input peer_tx);
   modport peer (input line_d2p, output peer_tx);
endinterface
`default_nettype wire

// file: hdl/ufb_device.sv
`timescale 1ns/100ps
`default_nettype none
module ufb_device #(
   parameter int DIV_W = ufb_pkg::DIV_W
) (
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   ufb_link_if.device link,
   input wire logic i_global_on_wr,
   input wire logic i_global_on,
   input wire logic i_word_length_sel,
   input wire logic i_parity_on,
   input wire logic i_parity_type_sel,
   input wire logic i_stop_count_sel,
   input wire logic i_speed_select,
   input wire logic i_addr_detect_on,
   input wire logic [DIV_W-1:0] i_divider_value,
   input wire logic i_dir_wr,
   input wire logic i_tx_on,
   input wire logic i_rx_on,
   input wire logic i_send_break_req,
   input wire logic i_tx_wr,
   input wire logic [8:0] i_tx_data,
   input wire logic i_rx_rd,
   input wire logic i_flag_clr,
   output logic o_serial_global_on,
   output logic o_tx_on,
   output logic o_rx_on,
   output logic [8:0] o_rx_data,
   output logic o_rx_avail_flag,
   output logic o_overrun_flag,
   output logic o_framing_err_flag,
   output logic o_parity_err_flag,
   output logic o_noise_flag,
   output logic o_tx_idle_flag,
   output logic o_tx_empty_flag,
   output logic o_rx_idle_flag
);
   typedef struct packed {
      logic on;
      logic txe;
      logic rxe;
      logic brk;
      logic w9;
      logic par;
      logic odd;
      logic st2;
      logic hs;
      logic adr;
      logic [DIV_W-1:0] n;
      logic [5:0] pre;
      logic [DIV_W-1:0] cnt;
      logic tick;
      logic pin_oe;
      logic pin;
      ufb_pkg::ufb_phase_t tph;
      logic [8:0] tsr;
      logic [3:0] tbit;
      logic [3:0] tsub;
      logic [8:0] thold;
      logic tfull;
      ufb_pkg::ufb_phase_t rph;
      logic [8:0] rsr;
      logic [3:0] rbit;
      logic [3:0] rsub;
      logic [2:0] maj;
      logic [8:0] rdat;
      logic ravail;
      logic ovr;
      logic fer;
      logic per;
      logic nf;
      logic tx_idle_flag;
      logic tempty;
      logic rx_idle_flag;
   } ufb_dev_t;
   ufb_dev_t s;
   ufb_dev_t next_s;
   logic txa;
   logic rxa;

   function automatic logic maj3(input logic [2:0] v);
      maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
   endfunction

   // Bits carried per word including parity or address slot
   function automatic logic [3:0] wlen(input logic w9);
      wlen = w9 ? 4'(ufb_pkg::WORD9) : 4'(ufb_pkg::WORD8);
   endfunction

   // Parity over the data part only; odd select flips it
   function automatic logic par_of(input logic [8:0] d, input logic w9, input logic odd);
      logic [8:0] m;
      m = w9 ? 9'h0FF : 9'h07F;
      par_of = (^(d & m)) ^ odd;
   endfunction

   assign txa = s.on & s.txe;
   assign rxa = s.on & s.rxe;

   always_comb begin
      logic [8:0] rw;
      rw = 9'h000;
      next_s = s;
      next_s.tick = 1'h0;
      if (i_dir_wr) begin
         next_s.w9 = i_word_length_sel;
         next_s.par = i_parity_on;
         next_s.odd = i_parity_type_sel;
         next_s.st2 = i_stop_count_sel;
         next_s.hs = i_speed_select;
         next_s.adr = i_addr_detect_on;
         next_s.n = i_divider_value;
         next_s.txe = i_tx_on;
         next_s.rxe = i_rx_on;
         next_s.brk = i_send_break_req;
      end
      // Prescale then reload divider, shared by both directions
      // reload free-running counter
      if (s.pre == 6'((s.hs ? ufb_pkg::HIGH_PRESCALE : ufb_pkg::LOW_PRESCALE) / ufb_pkg::RX_OS) - 6'h1
          || s.pre >= 6'(ufb_pkg::LOW_PRESCALE / ufb_pkg::RX_OS) - 6'h1) begin
         next_s.pre = 6'h0;
         if (s.cnt == 8'h0) begin
            next_s.cnt = s.n;
            next_s.tick = 1'h1;
         end else begin
            next_s.cnt = s.cnt - 8'h1;
         end
      end else begin
         next_s.pre = s.pre + 6'h1;
      end
      // Tick is 16x bit rate: 64 or 16 clocks per bit times N+1
      // prescale by speed
      if (i_tx_wr && s.tempty) begin
         next_s.thold = i_tx_data;
         next_s.tfull = 1'h1;
         next_s.tempty = 1'h0;
         next_s.tx_idle_flag = 1'h0;
      end
      // Transmitter
      if (txa && s.tick) begin
         next_s.tsub = s.tsub + 4'h1;
         if (s.tsub == 4'hF) begin
            unique case (s.tph)
               ufb_pkg::UFB_IDLE: begin
                  if (s.tfull) begin
                     next_s.tsr = s.thold;
                     if (s.par) begin
                        next_s.tsr[wlen(s.w9)-4'h1] = par_of(s.thold, s.w9, s.odd);
                     end
                     next_s.tfull = 1'h0;
                     next_s.tempty = 1'h1;
                     next_s.tph = ufb_pkg::UFB_START;
                  end
               end
               ufb_pkg::UFB_START: begin
                  next_s.tph = ufb_pkg::UFB_DATA;
                  next_s.tbit = 4'h0;
               end
               ufb_pkg::UFB_DATA: begin
                  next_s.tsr = {1'h0, s.tsr[8:1]};
                  next_s.tbit = s.tbit + 4'h1;
                  if (s.tbit == wlen(s.w9) - 4'h1) begin
                     next_s.tph = ufb_pkg::UFB_STOP1;
                  end
               end
               ufb_pkg::UFB_STOP1: begin
                  next_s.tph = s.st2 ? ufb_pkg::UFB_STOP2 : ufb_pkg::UFB_IDLE;
                  if (!s.st2 && !s.tfull) next_s.tx_idle_flag = 1'h1;
               end
               default: begin
                  next_s.tph = ufb_pkg::UFB_IDLE;
                  if (!s.tfull) next_s.tx_idle_flag = 1'h1;
               end
            endcase
         end
      end
      unique case (s.tph)
         ufb_pkg::UFB_START: next_s.pin = 1'h0;
         ufb_pkg::UFB_DATA: next_s.pin = s.brk ? 1'h0 : s.tsr[0];
         default: next_s.pin = 1'h1;
      endcase
      next_s.pin_oe = s.on & s.txe & s.rxe;
      // Software clears first, so a same-cycle hardware set wins
      if (i_rx_rd) next_s.ravail = 1'h0;
      if (i_flag_clr) begin
         next_s.ovr = 1'h0;
         next_s.fer = 1'h0;
         next_s.per = 1'h0;
         next_s.nf = 1'h0;
      end
      // Receiver: 16 samples per bit, majority of middle three
      if (rxa && s.tick) begin
         next_s.rsub = s.rsub + 4'h1;
         if (s.rsub >= 4'h7 && s.rsub <= 4'h9) begin
            next_s.maj = {s.maj[1:0], link.peer_tx};
         end
         unique case (s.rph)
            ufb_pkg::UFB_IDLE: begin
               next_s.rsub = 4'h0;
               if (!link.peer_tx) begin
                  next_s.rph = ufb_pkg::UFB_START;
                  next_s.rx_idle_flag = 1'h0;
               end
            end
            default: begin
               if (s.rsub == 4'hF) begin
                  if (s.maj != 3'h0 && s.maj != 3'h7) next_s.nf = 1'h1;
                  if (s.rph == ufb_pkg::UFB_START) begin
                     next_s.rph = maj3(s.maj) ? ufb_pkg::UFB_IDLE : ufb_pkg::UFB_DATA;
                     next_s.rbit = 4'h0;
                     next_s.rx_idle_flag = maj3(s.maj);
                  end else if (s.rph == ufb_pkg::UFB_DATA) begin
                     next_s.rsr = {maj3(s.maj), s.rsr[8:1]};
                     next_s.rbit = s.rbit + 4'h1;
                     if (s.rbit == wlen(s.w9) - 4'h1) next_s.rph = ufb_pkg::UFB_STOP1;
                  end else begin
                     next_s.rph = ufb_pkg::UFB_IDLE;
                     next_s.rx_idle_flag = 1'h1;
                     if (!maj3(s.maj)) next_s.fer = 1'h1;
                     // Align to bit 0 for 8-bit words
                     rw = s.w9 ? s.rsr : {1'h0, s.rsr[8:1]};
                     if (s.par && par_of(rw, s.w9, s.odd) != rw[wlen(s.w9)-4'h1]) next_s.per = 1'h1;
                     if (!(s.adr && !rw[wlen(s.w9)-4'h1])) begin
                        // A read in this cycle frees the slot
                        if (next_s.ravail) next_s.ovr = 1'h1;
                        else begin
                           next_s.rdat = rw;
                           next_s.ravail = 1'h1;
                        end
                     end
                  end
               end
            end
         endcase
      end
      if (i_global_on_wr) next_s.on = i_global_on;
      if (!s.on) begin
         next_s.txe = 1'h0;
         next_s.rxe = 1'h0;
         next_s.brk = 1'h0;
         next_s.tfull = 1'h0;
         next_s.ravail = 1'h0;
         next_s.ovr = 1'h0;
         next_s.fer = 1'h0;
         next_s.per = 1'h0;
         next_s.nf = 1'h0;
         next_s.tx_idle_flag = 1'h1;
         next_s.tempty = 1'h1;
         next_s.rx_idle_flag = 1'h1;
         next_s.tph = ufb_pkg::UFB_IDLE;
         next_s.rph = ufb_pkg::UFB_IDLE;
         next_s.pin_oe = 1'h0;
         next_s.tsub = 4'h0;
         if (i_global_on_wr && i_global_on && i_dir_wr) begin
            next_s.txe = i_tx_on;
            next_s.rxe = i_rx_on;
         end
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         s <= '0;
         s.w9 <= ufb_pkg::FMT_WORD9_RST;
         s.par <= ufb_pkg::FMT_PARITY_RST;
         s.st2 <= ufb_pkg::FMT_STOP2_RST;
         s.pin <= 1'h1;
         s.tx_idle_flag <= 1'h1;
         s.tempty <= 1'h1;
         s.rx_idle_flag <= 1'h1;
         s.tph <= ufb_pkg::UFB_IDLE;
         s.rph <= ufb_pkg::UFB_IDLE;
      end else begin
         s <= next_s;
      end
   end

   assign link.dev_tx = s.pin;
   assign link.dev_tx_oe = s.pin_oe;
   assign o_serial_global_on = s.on;
   assign o_tx_on = s.txe;
   assign o_rx_on = s.rxe;
   assign o_rx_data = s.rdat;
   assign o_rx_avail_flag = s.ravail;
   assign o_overrun_flag = s.ovr;
   assign o_framing_err_flag = s.fer;
   assign o_parity_err_flag = s.per;
   assign o_noise_flag = s.nf;
   assign o_tx_idle_flag = s.tx_idle_flag;
   assign o_tx_empty_flag = s.tempty;
   assign o_rx_idle_flag = s.rx_idle_flag;
endmodule
`default_nettype wire

// file: hdl/ufb_peer.sv
`timescale 1ns/100ps
`default_nettype none
module ufb_peer (
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   ufb_link_if.peer link,
   input wire logic [15:0] i_bit_clocks,
   input wire logic i_word_length_sel,
   input wire logic i_parity_on,
   input wire logic i_parity_type_sel,
   input wire logic i_stop_count_sel,
   input wire logic i_send,
   input wire logic [8:0] i_data,
   output logic o_busy,
   output logic o_rx_valid,
   output logic [8:0] o_rx_data,
   output logic o_rx_err
);
   typedef struct packed {
      logic [15:0] cnt;
      logic [3:0] tpos;
      logic [11:0] tsh;
      logic busy;
      logic line;
      logic [15:0] rcnt;
      logic [3:0] rpos;
      logic [10:0] rsh;
      logic rbusy;
      logic rv;
      logic [8:0] rd;
      logic re;
   } ufb_peer_t;
   ufb_peer_t s;
   ufb_peer_t next_s;
   logic [3:0] flen;

   // Frame length: start + word + one or two stop bits per stop_count_sel
   assign flen = 4'h1 + (i_word_length_sel ? 4'h9 : 4'h8) + (i_stop_count_sel ? 4'h2 : 4'h1);

   always_comb begin
      logic [8:0] w;
      w = i_data;
      next_s = s;
      next_s.rv = 1'h0;
      if (i_parity_on) begin
         if (i_word_length_sel) w[8] = (^i_data[7:0]) ^ i_parity_type_sel;
         else w[7] = (^i_data[6:0]) ^ i_parity_type_sel;
      end
      if (!s.busy) begin
         next_s.line = 1'h1;
         if (i_send) begin
            next_s.tsh = i_word_length_sel ? {2'h3, w, 1'h0} : {3'h7, w[7:0], 1'h0};
            next_s.busy = 1'h1;
            next_s.tpos = 4'h0;
            next_s.cnt = 16'h0;
         end
      end else begin
         next_s.line = s.tsh[0];
         next_s.cnt = s.cnt + 16'h1;
         if (s.cnt + 16'h1 >= i_bit_clocks) begin
            next_s.cnt = 16'h0;
            next_s.tsh = {1'h1, s.tsh[11:1]};
            next_s.tpos = s.tpos + 4'h1;
            if (s.tpos + 4'h1 == flen) next_s.busy = 1'h0;
         end
      end
      // Receive: sample mid-bit
      if (!s.rbusy) begin
         if (!link.line_d2p) begin
            next_s.rbusy = 1'h1;
            next_s.rcnt = {1'h0, i_bit_clocks[15:1]};
            next_s.rpos = 4'h0;
         end
      end else if (s.rcnt == 16'h0) begin
         next_s.rcnt = i_bit_clocks - 16'h1;
         next_s.rsh = {link.line_d2p, s.rsh[10:1]};
         next_s.rpos = s.rpos + 4'h1;
         if (s.rpos == (i_word_length_sel ? 4'hA : 4'h9)) begin
            next_s.rbusy = 1'h0;
            next_s.rv = 1'h1;
            next_s.rd = i_word_length_sel ? s.rsh[10:2] : {1'h0, s.rsh[10:3]};
            next_s.re = !link.line_d2p;
         end
      end else begin
         next_s.rcnt = s.rcnt - 16'h1;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         s <= '0;
         s.line <= 1'h1;
      end else begin
         s <= next_s;
      end
   end

   assign link.peer_tx = s.line;
   assign o_busy = s.busy;
   assign o_rx_valid = s.rv;
   assign o_rx_data = s.rd;
   assign o_rx_err = s.re;
endmodule
`default_nettype wire

// file: tb/ufb_link_chk.sv
`timescale 1ns/100ps
`default_nettype none
module ufb_link_chk (
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   input wire logic dev_tx,
   input wire logic dev_tx_oe,
   input wire logic line_d2p,
   input wire logic [15:0] i_bit_clocks,
   input wire logic o_serial_global_on,
   input wire logic o_tx_on,
   input wire logic o_rx_on,
   input wire logic o_rx_avail_flag,
   input wire logic o_tx_idle_flag,
   input wire logic o_tx_empty_flag,
   input wire logic o_rx_idle_flag
);
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (i_sys_rst);
   logic [15:0] low_run;
   logic all_on;
   assign all_on = o_serial_global_on && o_tx_on && o_rx_on;
   ////////////////////////////////////////////////////////////
   // Released line restarts the count, so aborts never match
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst || line_d2p || !dev_tx_oe) begin
         low_run <= 16'h0000;
      end else begin
         low_run <= low_run + 16'h0001;
      end
   end
   sequence s_on2;
      all_on ##1 all_on;
   endsequence
   sequence s_off2;
      !o_serial_global_on ##1 !o_serial_global_on;
   endsequence
   ////////////////////////////////////////////////////////////
   a_oe_needs_all: assert property (dev_tx_oe |-> $past(all_on))
      else $error("line driven without all enables");
   a_on_gives_oe: assert property (s_on2 |-> dev_tx_oe)
      else $error("line not driven while enabled");
   a_off_releases: assert property (!o_serial_global_on |=> !dev_tx_oe)
      else $error("line driven while off");
   a_off_clears: assert property (s_off2 |-> !o_tx_on && !o_rx_on && o_tx_idle_flag && o_rx_idle_flag)
      else $error("state not cleared while off");
   a_off_empties: assert property (s_off2 |-> !o_rx_avail_flag && o_tx_empty_flag)
      else $error("buffers not empty while off");
   a_abort_now: assert property ($fell(o_serial_global_on) |=> line_d2p [*4])
      else $error("frame continued after off");
   a_idle_high: assert property (dev_tx_oe && o_tx_idle_flag && $past(o_tx_idle_flag) |-> dev_tx)
      else $error("idle line not high");
   a_bit_whole: assert property ($rose(line_d2p) && dev_tx_oe |-> low_run != 16'h0000 && low_run % i_bit_clocks == 16'h0000)
      else $error("low run not whole bit times");
endmodule
`default_nettype wire

// file: tb/uart_format_baud_enable_test.sv
`timescale 1ns/100ps
`default_nettype none
module uart_format_baud_enable_test;
   logic i_ref_clk = 1'h0, i_sys_rst = 1'h1, g_wr = 1'h0, g_on = 1'h0, d_wr = 1'h0, word9 = 1'h0;
   logic par_on = 1'h0, par_odd = 1'h0, stop2 = 1'h0, fast = 1'h0, addr_on = 1'h0, tx_en = 1'h0;
   logic rx_en = 1'h0, tx_wr = 1'h0, rx_rd = 1'h0, flg_clr = 1'h0, p_send = 1'h0, skip_peer = 1'h0;
   logic [7:0] divv = 8'h00;
   logic [8:0] tx_data = 9'h000, p_data = 9'h000, rx_data, p_rx_data;
   logic [15:0] bit_clks = 16'h0040;
   logic gon, txo, rxo, rx_avail, ovr, framing_err_flag, parity_err_flag, nf, tx_idle_flag, tempty, rx_idle_flag, p_busy, p_valid, p_err;
   logic line_d2p;
   logic [8:0] exp_dev[$], exp_peer[$];
   int errors = 0, checked = 0, cyc = 0, seed = 32'hEBCF;
   ufb_link_if ufb_link_if_inst ();
   assign line_d2p = ufb_link_if_inst.line_d2p;
   ufb_device ufb_device_inst (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .link(ufb_link_if_inst),
      .i_global_on_wr(g_wr), .i_global_on(g_on), .i_word_length_sel(word9), .i_parity_on(par_on),
      .i_parity_type_sel(par_odd), .i_stop_count_sel(stop2), .i_speed_select(fast),
      .i_addr_detect_on(addr_on), .i_divider_value(divv), .i_dir_wr(d_wr), .i_tx_on(tx_en),
      .i_rx_on(rx_en), .i_send_break_req(1'h0), .i_tx_wr(tx_wr), .i_tx_data(tx_data), .i_rx_rd(rx_rd),
      .i_flag_clr(flg_clr), .o_serial_global_on(gon), .o_tx_on(txo), .o_rx_on(rxo),
      .o_rx_data(rx_data), .o_rx_avail_flag(rx_avail), .o_overrun_flag(ovr), .o_framing_err_flag(framing_err_flag),
      .o_parity_err_flag(parity_err_flag), .o_noise_flag(nf), .o_tx_idle_flag(tx_idle_flag), .o_tx_empty_flag(tempty),
      .o_rx_idle_flag(rx_idle_flag));
   ufb_peer ufb_peer_inst (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .link(ufb_link_if_inst),
      .i_bit_clocks(bit_clks), .i_word_length_sel(word9), .i_parity_on(par_on),
      .i_parity_type_sel(par_odd), .i_stop_count_sel(stop2), .i_send(p_send), .i_data(p_data),
      .o_busy(p_busy), .o_rx_valid(p_valid), .o_rx_data(p_rx_data), .o_rx_err(p_err));
   ufb_link_chk ufb_link_chk_inst (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
      .dev_tx(ufb_link_if_inst.dev_tx), .dev_tx_oe(ufb_link_if_inst.dev_tx_oe), .line_d2p(line_d2p),
      .i_bit_clocks(bit_clks), .o_serial_global_on(gon), .o_tx_on(txo), .o_rx_on(rxo),
      .o_rx_avail_flag(rx_avail), .o_tx_idle_flag(tx_idle_flag), .o_tx_empty_flag(tempty),
      .o_rx_idle_flag(rx_idle_flag));
   always #20 i_ref_clk = ~i_ref_clk;
   ////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic check(input string n, input logic [8:0] s, input logic [8:0] e);
      checked++;
      if (s !== e) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask
   function automatic logic [8:0] dmask();
      return par_on ? (word9 ? 9'h0FF : 9'h07F) : (word9 ? 9'h1FF : 9'h0FF);
   endfunction
   task automatic set_global(input logic v);
      @(posedge i_ref_clk);
      {g_wr, g_on} <= {1'h1, v};
      @(posedge i_ref_clk);
      g_wr <= 1'h0;
      repeat (3) @(negedge i_ref_clk);
   endtask
   task automatic cfg(input logic w, p, o, s, f, a, input logic [7:0] n);
      @(posedge i_ref_clk);
      {word9, par_on, par_odd, stop2, fast, addr_on, divv} <= {w, p, o, s, f, a, n};
      {tx_en, rx_en, d_wr} <= 3'h7;
      bit_clks <= (f ? 16'h0010 : 16'h0040) * ({8'h00, n} + 16'h0001);
      @(posedge i_ref_clk);
      d_wr <= 1'h0;
      repeat (3) @(negedge i_ref_clk);
   endtask
   task automatic tx_write(input logic [8:0] d);
      for (int i = 0; i < 9000 && !tempty; i++) @(negedge i_ref_clk);
      @(posedge i_ref_clk);
      {tx_wr, tx_data} <= {1'h1, d};
      @(posedge i_ref_clk);
      tx_wr <= 1'h0;
   endtask
   // Samples the wire itself at mid bit, so the far end cannot mask it
   task automatic dev_send(input logic [8:0] d);
      logic [8:0] w;
      w = d;
      if (par_on) w[word9 ? 8 : 7] = ^(d & dmask()) ^ par_odd;
      exp_peer.push_back(d & dmask());
      tx_write(d);
      for (int i = 0; i < 9000 && line_d2p; i++) @(negedge i_ref_clk);
      repeat (bit_clks / 2) @(negedge i_ref_clk);
      check("start", {8'h00, line_d2p}, 9'h000);
      for (int i = 0; i < (word9 ? 9 : 8); i++) begin
         repeat (bit_clks) @(negedge i_ref_clk);
         check("bit", {8'h00, line_d2p}, {8'h00, w[i]});
      end
      for (int i = 0; i <= stop2; i++) begin
         repeat (bit_clks) @(negedge i_ref_clk);
         check("stop", {8'h00, line_d2p}, 9'h001);
      end
      repeat (bit_clks) @(negedge i_ref_clk);
   endtask
   task automatic peer_send(input logic [8:0] d, input logic keep);
      if (keep) exp_dev.push_back(d & dmask());
      @(posedge i_ref_clk);
      {p_send, p_data} <= {1'h1, d};
      @(posedge i_ref_clk);
      p_send <= 1'h0;
      repeat (2) @(negedge i_ref_clk);
      for (int i = 0; i < 60000 && p_busy; i++) @(negedge i_ref_clk);
      repeat (bit_clks * 2) @(negedge i_ref_clk);
   endtask
   ////////////////////////////////////////////////////////////
   always @(negedge i_ref_clk) begin
      if (p_valid && !skip_peer) begin
         check("peer_data", p_rx_data & dmask(), exp_peer.size() ? exp_peer.pop_front() : 'x);
         check("peer_stop", {8'h00, p_err}, 9'h000);
      end
      if (rx_avail && !rx_rd) begin
         check("dev_data", rx_data & dmask(), exp_dev.size() ? exp_dev.pop_front() : 'x);
         check("dev_parity", {8'h00, parity_err_flag}, 9'h000);
      end
   end
   always @(posedge i_ref_clk) begin
      rx_rd <= rx_avail && !rx_rd;
      cyc++;
      if (cyc == 100000) begin
         errors++;
         report_and_stop();
      end
   end
   initial begin
      repeat (5) @(posedge i_ref_clk);
      i_sys_rst <= 1'h0;
      @(negedge i_ref_clk);
      check("idle_flags", {6'h00, tx_idle_flag, tempty, rx_idle_flag}, 9'h007);
      set_global(1'h1);
      check("global_on", {8'h00, gon}, 9'h001);
      for (int k = 0; k < 16; k++) begin
         cfg(k[0], k[1], k[2], k[3], k[0] | k[2], 1'h0, {7'h00, k[1]});
         dev_send(9'($random(seed)));
         peer_send(9'($random(seed)), 1'h1);
      end
      $display("format sweep done");
      // Address mode: a word with top bit clear must never surface
      cfg(1'h1, 1'h0, 1'h0, 1'h0, 1'h1, 1'h1, 8'h00);
      peer_send(9'h055, 1'h0);
      peer_send(9'h1AA, 1'h1);
      $display("address mode done");
      cfg(1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 8'h01);
      skip_peer = 1'h1;
      tx_write(9'h0F0);
      repeat (200) @(posedge i_ref_clk);
      set_global(1'h0);
      check("line_rel", {8'h00, line_d2p}, 9'h001);
      check("enables", {7'h00, txo, rxo}, 9'h000);
      check("empty", {7'h00, tempty, rx_avail}, 9'h002);
      check("off_flags", {5'h00, ovr, framing_err_flag, parity_err_flag, nf}, 9'h000);
      check("off_idle", {7'h00, tx_idle_flag, rx_idle_flag}, 9'h003);
      repeat (3000) @(posedge i_ref_clk);
      skip_peer = 1'h0;
      set_global(1'h1);
      check("tx_on_off", {8'h00, txo}, 9'h000);
      @(posedge i_ref_clk);
      flg_clr <= 1'h1;
      @(posedge i_ref_clk);
      flg_clr <= 1'h0;
      repeat (2) @(negedge i_ref_clk);
      check("err_flags", {5'h00, ovr, framing_err_flag, parity_err_flag, nf}, 9'h000);
      $display("disable and resume done");
      // Divider at its top value, slowest fast-mode rate
      cfg(1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 8'hFF);
      dev_send(9'($random(seed)));
      check("pending", 9'(exp_peer.size() + exp_dev.size()), 9'h000);
      $display("divider top done");
      report_and_stop();
   end
endmodule
`default_nettype wire
